// [design/swa_regs.svh]
// register offsets, field positions, reset values and timing figures for the arithmetic unit
`ifndef SWA_REGS_SVH
`define SWA_REGS_SVH

// register byte addresses
`define SWA_CTRL_ADDR 12'h000
`define SWA_STAT_ADDR 12'h004
`define SWA_OPA_ADDR 12'h008
`define SWA_OPB_ADDR 12'h00C
`define SWA_RES0_ADDR 12'h010
`define SWA_RES1_ADDR 12'h014
`define SWA_FAULT_ADDR 12'h018

// control register fields
`define SWA_CTRL_OP_LSB 0
`define SWA_CTRL_OP_MSB 2
`define SWA_CTRL_COND_BIT 3
`define SWA_CTRL_START_BIT 8

// status register fields
`define SWA_STAT_CY_BIT 0
`define SWA_STAT_EQ_BIT 1
`define SWA_STAT_POVF_BIT 2
`define SWA_STAT_NOVF_BIT 3
`define SWA_STAT_FAULT_BIT 4
`define SWA_STAT_BUSY_BIT 5

// fault register fields, one per indirect-access fault cause
`define SWA_FAULT_MISSING_BIT 0
`define SWA_FAULT_NONBCD_BIT 1
`define SWA_FAULT_BOUND_BIT 2

// reset values
`define SWA_FLAGS_RST 5'h00
`define SWA_WORD_RST 32'h0000_0000

// divider iterations, one quotient bit per clock
`define SWA_DIV_STEPS 6'd32

`endif

// [design/swa_pkg.sv]
// types shared by the signed wide arithmetic unit
package swa_pkg;
   // operation selector
   typedef enum logic [2:0] {
      SWA_OP_SUB32 = 3'h0,
      SWA_OP_MUL16 = 3'h1,
      SWA_OP_MUL32 = 3'h2,
      SWA_OP_DIV16 = 3'h3,
      SWA_OP_DIV32 = 3'h4
   } swa_op_t;

   // sequencer states, one-hot
   typedef enum logic [2:0] {
      SWA_IDLE = 3'b001,
      SWA_DIV = 3'b010,
      SWA_DONE = 3'b100
   } swa_state_t;
endpackage : swa_pkg

// [design/swa_unit.sv]
// signed wide arithmetic unit: 32-bit subtract with borrow, signed multiply and divide
// Summary of operation
// - condition false: no result or flag change
// - difference is A minus B minus borrow
// - negative difference sets borrow, two's complement stored
// - subtract zero flag covers full difference
// - signed overflow and underflow flags for subtract
// - flags sit at fixed status bit positions
// - indirect access fault raises error flag
// - 16-bit multiply gives 32-bit product, low first
// - 16-bit multiply zero flag on whole product
// - 32-bit multiply gives 64-bit product, four words
// - 32-bit multiply zero flag on all words
// - 16-bit divide: quotient then remainder
// - 16-bit divide zero flag on quotient only
// - 32-bit divide: quotient words 0-1, remainder 2-3
// - zero divisor raises error flag
// - 32-bit divide zero flag on quotient only
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "swa_regs.svh"

module swa_unit (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o
);
   import swa_pkg::*;

   logic [31:0] ctrl_reg; // op select and condition
   logic [31:0] opa_reg; // first operand pair, low word in bits 15:0
   logic [31:0] opb_reg; // second operand pair
   logic [31:0] res0_reg; // result words 0 and 1
   logic [31:0] res1_reg; // result words 2 and 3
   logic [2:0] fault_reg; // fault causes written over the bus at the fault register address
   logic cy_reg, eq_reg, povf_reg, novf_reg, err_reg; // status flags
   swa_state_t state_reg;
   swa_op_t op_reg; // operation being executed
   logic [5:0] cnt_reg; // divider iterations left
   logic [31:0] dvd_reg; // dividend magnitude, shifted out as quotient forms
   logic [31:0] dvs_reg; // divisor magnitude
   logic [32:0] rem_reg; // partial remainder
   logic qneg_reg, rneg_reg; // result signs

   logic setup_w, access_w, wr_w, start_w;
   assign setup_w = psel_i & ~penable_i;
   assign access_w = psel_i & penable_i;
   assign pready_o = 1'b1; // every access completes at once
   assign wr_w = access_w & pwrite_i;
   // writing a one to the start bit launches the selected operation
   assign start_w = wr_w && (paddr_i == `SWA_CTRL_ADDR) && pwdata_i[`SWA_CTRL_START_BIT]
      && (state_reg == SWA_IDLE);

   // unmapped addresses answer with an error
   always_comb begin
      pslverr_o = 1'b0;
      if (access_w) begin
         unique case (paddr_i)
            `SWA_CTRL_ADDR, `SWA_STAT_ADDR, `SWA_OPA_ADDR, `SWA_OPB_ADDR,
            `SWA_RES0_ADDR, `SWA_RES1_ADDR, `SWA_FAULT_ADDR: pslverr_o = 1'b0;
            default: pslverr_o = 1'b1;
         endcase
      end
   end

   // operand and control registers; operands locked while busy
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ctrl_reg <= `SWA_WORD_RST;
         opa_reg <= `SWA_WORD_RST;
         opb_reg <= `SWA_WORD_RST;
         fault_reg <= 3'h0;
      end else if (wr_w && state_reg == SWA_IDLE) begin
         if (paddr_i == `SWA_CTRL_ADDR) begin
            ctrl_reg <= {28'h0000000, pwdata_i[3:0]};
         end
         if (paddr_i == `SWA_OPA_ADDR) begin
            opa_reg <= pwdata_i;
         end
         if (paddr_i == `SWA_OPB_ADDR) begin
            opb_reg <= pwdata_i;
         end
         if (paddr_i == `SWA_FAULT_ADDR) begin
            fault_reg <= pwdata_i[2:0];
         end
      end
   end

   // combinational arithmetic for single-cycle operations
   logic [32:0] diff_w;
   logic signed [33:0] sdiff_w;
   logic signed [31:0] p16_w;
   logic signed [63:0] p32_w;
   logic fault_w, div_w, dz_w;
   assign diff_w = {1'b0, opa_reg} - {1'b0, opb_reg} - {32'h0, cy_reg};
   assign sdiff_w = {{2{opa_reg[31]}}, opa_reg} - {{2{opb_reg[31]}}, opb_reg}
      - {33'h0, cy_reg};
   assign p16_w = $signed(opa_reg[15:0]) * $signed(opb_reg[15:0]);
   assign p32_w = $signed(opa_reg) * $signed(opb_reg);
   assign fault_w = |fault_reg;
   assign div_w = (ctrl_reg[2:0] == SWA_OP_DIV16) || (ctrl_reg[2:0] == SWA_OP_DIV32);
   assign dz_w = (ctrl_reg[2:0] == SWA_OP_DIV16) ? (opb_reg[15:0] == 16'h0000)
      : (opb_reg == 32'h0000_0000);

   // divider operand magnitudes
   logic [31:0] a_mag_w, b_mag_w;
   logic a_neg_w, b_neg_w;
   always_comb begin
      if (ctrl_reg[2:0] == SWA_OP_DIV16) begin
         a_neg_w = opa_reg[15];
         b_neg_w = opb_reg[15];
         a_mag_w = {16'h0000, a_neg_w ? 16'(-opa_reg[15:0]) : opa_reg[15:0]};
         b_mag_w = {16'h0000, b_neg_w ? 16'(-opb_reg[15:0]) : opb_reg[15:0]};
      end else begin
         a_neg_w = opa_reg[31];
         b_neg_w = opb_reg[31];
         a_mag_w = a_neg_w ? 32'(-opa_reg) : opa_reg;
         b_mag_w = b_neg_w ? 32'(-opb_reg) : opb_reg;
      end
   end

   // one restoring step of the divider
   logic [32:0] trial_w;
   logic [32:0] shifted_w;
   assign shifted_w = {rem_reg[31:0], dvd_reg[31]};
   assign trial_w = shifted_w - {1'b0, dvs_reg};

   // sequencer: single-cycle ops finish in idle, division iterates
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_reg <= SWA_IDLE;
         op_reg <= SWA_OP_SUB32;
         cnt_reg <= 6'd0;
         dvd_reg <= `SWA_WORD_RST;
         dvs_reg <= `SWA_WORD_RST;
         rem_reg <= 33'h0;
         qneg_reg <= 1'b0;
         rneg_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            SWA_IDLE: begin
               // a zero divisor or fault skips the divider entirely
               if (start_w && ctrl_reg[`SWA_CTRL_COND_BIT] && div_w && !dz_w && !fault_w) begin
                  state_reg <= SWA_DIV;
                  op_reg <= swa_op_t'(ctrl_reg[2:0]);
                  cnt_reg <= `SWA_DIV_STEPS;
                  dvd_reg <= a_mag_w;
                  dvs_reg <= b_mag_w;
                  rem_reg <= 33'h0;
                  qneg_reg <= a_neg_w ^ b_neg_w;
                  rneg_reg <= a_neg_w;
               end
            end
            SWA_DIV: begin
               // shift one dividend bit in per clock, keep quotient bit in its place
               if (trial_w[32]) begin
                  rem_reg <= shifted_w;
                  dvd_reg <= {dvd_reg[30:0], 1'b0};
               end else begin
                  rem_reg <= trial_w;
                  dvd_reg <= {dvd_reg[30:0], 1'b1};
               end
               cnt_reg <= cnt_reg - 6'd1;
               if (cnt_reg == 6'd1) begin
                  state_reg <= SWA_DONE;
               end
            end
            SWA_DONE: state_reg <= SWA_IDLE;
            default: state_reg <= SWA_IDLE;
         endcase
      end
   end

   // signed quotient and remainder from magnitudes
   logic [31:0] q_w, r_w;
   assign q_w = qneg_reg ? 32'(-dvd_reg) : dvd_reg; // truncation toward zero
   assign r_w = rneg_reg ? 32'(-rem_reg[31:0]) : rem_reg[31:0];

   // result words and flags
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         res0_reg <= `SWA_WORD_RST;
         res1_reg <= `SWA_WORD_RST;
         {novf_reg, povf_reg, eq_reg, cy_reg, err_reg} <= `SWA_FLAGS_RST;
      end else if (start_w && ctrl_reg[`SWA_CTRL_COND_BIT]) begin
         err_reg <= fault_w || (div_w && dz_w);
         if (!fault_w) begin
            unique case (ctrl_reg[2:0])
               SWA_OP_SUB32: begin
                  res0_reg <= diff_w[31:0]; // low word then high word
                  cy_reg <= diff_w[32]; // borrow out
                  eq_reg <= (diff_w[31:0] == 32'h0000_0000);
                  povf_reg <= (sdiff_w > 34'sh0_7FFF_FFFF);
                  novf_reg <= (sdiff_w < -34'sh0_8000_0000);
               end
               SWA_OP_MUL16: begin
                  res0_reg <= p16_w;
                  eq_reg <= (p16_w == 32'sh0);
               end
               SWA_OP_MUL32: begin
                  res0_reg <= p32_w[31:0];
                  res1_reg <= p32_w[63:32];
                  eq_reg <= (p32_w == 64'sh0);
               end
               default: begin
                  // divide results land when the divider finishes
               end
            endcase
         end
      end else if (state_reg == SWA_DONE) begin
         if (op_reg == SWA_OP_DIV16) begin
            res0_reg <= {r_w[15:0], q_w[15:0]};
            eq_reg <= (q_w[15:0] == 16'h0000);
         end else begin
            res0_reg <= q_w;
            res1_reg <= r_w;
            eq_reg <= (q_w == 32'h0000_0000);
         end
      end
   end

   // read mux, registered data output
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         prdata_o <= `SWA_WORD_RST;
      end else if (setup_w && !pwrite_i) begin
         unique case (paddr_i)
            `SWA_CTRL_ADDR: prdata_o <= ctrl_reg;
            `SWA_STAT_ADDR: prdata_o <= {26'h0, state_reg != SWA_IDLE, err_reg, novf_reg,
               povf_reg, eq_reg, cy_reg}; // fixed bit positions
            `SWA_OPA_ADDR: prdata_o <= opa_reg;
            `SWA_OPB_ADDR: prdata_o <= opb_reg;
            `SWA_RES0_ADDR: prdata_o <= res0_reg;
            `SWA_RES1_ADDR: prdata_o <= res1_reg;
            `SWA_FAULT_ADDR: prdata_o <= {29'h0, fault_reg};
            default: prdata_o <= `SWA_WORD_RST;
         endcase
      end
   end

   // assertions
   property p_cond_off;
      @(posedge clk_i) disable iff (reset_i)
      (start_w && !ctrl_reg[`SWA_CTRL_COND_BIT]) |=> $stable(res0_reg) && $stable(cy_reg)
         && $stable(res1_reg) && $stable(eq_reg) && $stable(err_reg) && $stable(povf_reg)
         && $stable(novf_reg);
   endproperty
   a_cond_off: assert property (p_cond_off) else $error("result changed with condition off");

   property p_sub_borrow;
      @(posedge clk_i) disable iff (reset_i)
      (start_w && ctrl_reg[3] && !fault_w && ctrl_reg[2:0] == SWA_OP_SUB32)
      |=> cy_reg == ({1'b0, $past(opa_reg)} < {1'b0, $past(opb_reg)} + {32'h0, $past(cy_reg)});
   endproperty
   a_sub_borrow: assert property (p_sub_borrow) else $error("borrow flag wrong");

   property p_mul_keeps_cy;
      @(posedge clk_i) disable iff (reset_i)
      (start_w && ctrl_reg[2:0] != SWA_OP_SUB32) |=> $stable(cy_reg);
   endproperty
   a_mul_keeps_cy: assert property (p_mul_keeps_cy) else $error("borrow flag disturbed");

   property p_div_zero;
      @(posedge clk_i) disable iff (reset_i)
      (start_w && ctrl_reg[3] && div_w && dz_w) |=> err_reg ##1 state_reg == SWA_IDLE;
   endproperty
   a_div_zero: assert property (p_div_zero) else $error("zero divisor not flagged");

   property p_div_len;
      @(posedge clk_i) disable iff (reset_i)
      $rose(state_reg == SWA_DIV) |-> (state_reg == SWA_DIV)[*8] ##25 state_reg == SWA_DONE;
   endproperty
   a_div_len: assert property (p_div_len) else $error("divider length wrong");

   property p_fault;
      @(posedge clk_i) disable iff (reset_i)
      (start_w && ctrl_reg[3] && fault_w) |=> err_reg && $stable(res0_reg);
   endproperty
   a_fault: assert property (p_fault) else $error("access fault not flagged");

   property p_mul16_eq;
      @(posedge clk_i) disable iff (reset_i)
      (start_w && ctrl_reg[3] && !fault_w && ctrl_reg[2:0] == SWA_OP_MUL16)
      |=> eq_reg == ($past(opa_reg[15:0]) == 16'h0000 || $past(opb_reg[15:0]) == 16'h0000);
   endproperty
   a_mul16_eq: assert property (p_mul16_eq) else $error("multiply zero flag wrong");

   property p_div_eq;
      @(posedge clk_i) disable iff (reset_i)
      (state_reg == SWA_DONE && op_reg == SWA_OP_DIV32) |=> eq_reg == (res0_reg == 32'h0);
   endproperty
   a_div_eq: assert property (p_div_eq) else $error("divide zero flag wrong");

   // checks below work from the operands, not the datapath, except the result sign in the overflow check and a_mag_w/b_mag_w in the div16 check
   property p_sub_zero;
      @(posedge clk_i) disable iff (reset_i)
      (start_w && ctrl_reg[`SWA_CTRL_COND_BIT] && !fault_w && ctrl_reg[2:0] == SWA_OP_SUB32)
      |=> eq_reg == ($past(opa_reg) - $past(opb_reg) == 32'($past(cy_reg)));
   endproperty
   a_sub_zero: assert property (p_sub_zero) else $error("subtract zero flag wrong");

   // overflow only when operand signs differ and the result sign leaves the minuend's
   property p_sub_ovf;
      @(posedge clk_i) disable iff (reset_i)
      (start_w && ctrl_reg[`SWA_CTRL_COND_BIT] && !fault_w && ctrl_reg[2:0] == SWA_OP_SUB32)
      |=> povf_reg == (!$past(opa_reg[31]) && $past(opb_reg[31]) && res0_reg[31])
         && novf_reg == ($past(opa_reg[31]) && !$past(opb_reg[31]) && !res0_reg[31]);
   endproperty
   a_sub_ovf: assert property (p_sub_ovf) else $error("subtract overflow flags wrong");

   // a product is zero exactly when one factor is zero
   property p_mul32_eq;
      @(posedge clk_i) disable iff (reset_i)
      (start_w && ctrl_reg[`SWA_CTRL_COND_BIT] && !fault_w && ctrl_reg[2:0] == SWA_OP_MUL32)
      |=> eq_reg == ($past(opa_reg) == 32'h0000_0000 || $past(opb_reg) == 32'h0000_0000);
   endproperty
   a_mul32_eq: assert property (p_mul32_eq) else $error("mul32 zero flag wrong");

   // quotient is zero exactly when the dividend magnitude is below the divisor's
   property p_div16_eq;
      @(posedge clk_i) disable iff (reset_i)
      (state_reg == SWA_DONE && op_reg == SWA_OP_DIV16)
      |=> eq_reg == ($past(a_mag_w) < $past(b_mag_w));
   endproperty
   a_div16_eq: assert property (p_div16_eq) else $error("div16 zero flag wrong");

   // a zero divisor must leave every result word and the zero flag as they were
   property p_div_keeps;
      @(posedge clk_i) disable iff (reset_i)
      (start_w && ctrl_reg[`SWA_CTRL_COND_BIT] && div_w && dz_w)
      |=> $stable(res0_reg) && $stable(res1_reg) && $stable(eq_reg);
   endproperty
   a_div_keeps: assert property (p_div_keeps) else $error("div by zero changed");

   // operands and control stay locked while the divider still depends on them
   property p_busy_locks;
      @(posedge clk_i) disable iff (reset_i)
      (state_reg != SWA_IDLE) |=> $stable(opa_reg) && $stable(opb_reg) && $stable(ctrl_reg);
   endproperty
   a_busy_locks: assert property (p_busy_locks) else $error("busy lock broken");
endmodule : swa_unit

// [testbench/swa_unit_tb.sv]
// self-checking bench for the signed wide arithmetic unit over its register bus
`timescale 1ns/100ps
`include "swa_regs.svh"

module swa_unit_tb;
   import swa_pkg::*;
   logic clk_i = 1'b0; // bench clock, 100 MHz
   logic reset_i = 1'b1; // synchronous reset, held at start
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   int error_cnt = 0; // mismatches seen
   int total_checks = 0; // comparisons made
   int cyc_cnt = 0; // cycles since start, for the hang guard
   logic [31:0] rd; // data of the last read
   logic rerr; // slave error of the last transfer

   swa_unit i_dut (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .psel_i(psel_i),
      .penable_i(penable_i),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .pwdata_i(pwdata_i),
      .prdata_o(prdata_o),
      .pready_o(pready_o),
      .pslverr_o(pslverr_o)
   );

   // free-running clock
   always #5 clk_i = ~clk_i;

   // hang guard: the whole run needs under a thousand cycles only
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         conclude();
      end
   end

   // print counts and verdict, then stop
   task conclude;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude

   // compare one 32-bit result
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // one bus transfer; starts on a fresh edge so a release never meets a new setup
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      // the slave decides the wait; only the hang guard ends it
      while (pready_o !== 1'b1) @(posedge clk_i);
      rd = prdata_o;
      rerr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   // read a register and compare it
   task rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp, what);
   endtask : rdchk

   // load operands, start, wait out a divide, then check status and both result pairs
   task run(input swa_op_t op, input logic cond, input logic [31:0] a, input logic [31:0] b,
            input logic [31:0] r0, input logic [31:0] r1, input logic [31:0] st);
      int n;
      logic [31:0] ctl;
      ctl = 32'(op) | (32'(cond) << 3);
      apb(1'b1, `SWA_OPA_ADDR, a);
      apb(1'b1, `SWA_OPB_ADDR, b);
      apb(1'b1, `SWA_CTRL_ADDR, ctl);
      apb(1'b1, `SWA_CTRL_ADDR, ctl | 32'h0000_0100);
      apb(1'b0, `SWA_STAT_ADDR, 32'h0000_0000);
      // a real divide must still be running right after its start
      if (cond && ((op == SWA_OP_DIV16 && b[15:0] != 16'h0000) ||
                   (op == SWA_OP_DIV32 && b != 32'h0000_0000))) begin
         chk(rd & 32'h0000_0020, 32'h0000_0020, "busy");
      end
      n = 0;
      while (rd[5] === 1'b1 && n < 50) begin
         apb(1'b0, `SWA_STAT_ADDR, 32'h0000_0000);
         n++;
      end
      chk(rd, st, "status");
      rdchk(`SWA_RES0_ADDR, r0, "result low pair");
      rdchk(`SWA_RES1_ADDR, r1, "result high pair");
   endtask : run

   // main sequence
   initial begin
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      rdchk(`SWA_STAT_ADDR, 32'h0000_0000, "status after reset");
      rdchk(`SWA_RES0_ADDR, 32'h0000_0000, "res0 after reset");
      rdchk(`SWA_FAULT_ADDR, 32'h0000_0000, "fault after reset");
      // unmapped place answers with an error and zero data
      apb(1'b0, 12'h01C, 32'h0000_0000);
      chk({31'h0, rerr}, 32'h0000_0001, "slave error");
      chk(rd, 32'h0000_0000, "unmapped data");
      run(SWA_OP_SUB32, 1'b0, 32'h5, 32'h3, 32'h0, 32'h0, 32'h00);
      run(SWA_OP_SUB32, 1'b1, 32'h5, 32'h3, 32'h2, 32'h0, 32'h00);
      run(SWA_OP_SUB32, 1'b1, 32'h3, 32'h5, 32'hFFFF_FFFE, 32'h0, 32'h01);
      run(SWA_OP_MUL16, 1'b1, 32'hFFFD, 32'h5, 32'hFFFF_FFF1, 32'h0, 32'h01);
      run(SWA_OP_SUB32, 1'b1, 32'hA, 32'h4, 32'h5, 32'h0, 32'h00);
      run(SWA_OP_SUB32, 1'b1, 32'h7, 32'h7, 32'h0, 32'h0, 32'h02);
      run(SWA_OP_SUB32, 1'b1, 32'h7FFF_FFFF, 32'hFFFF_FFFF, 32'h8000_0000, 32'h0, 32'h05);
      run(SWA_OP_SUB32, 1'b1, 32'h8000_0000, 32'h0, 32'h7FFF_FFFF, 32'h0, 32'h08);
      run(SWA_OP_MUL16, 1'b1, 32'h0, 32'h1234, 32'h0, 32'h0, 32'h0A);
      run(SWA_OP_MUL32, 1'b1, 32'h0, 32'h5, 32'h0, 32'h0, 32'h0A);
      run(SWA_OP_MUL32, 1'b1, 32'h8000_0000, 32'h8000_0000, 32'h0, 32'h4000_0000, 32'h08);
      run(SWA_OP_MUL32, 1'b1, 32'hFFFF_FFFF, 32'h2, 32'hFFFF_FFFE, 32'hFFFF_FFFF, 32'h08);
      run(SWA_OP_DIV16, 1'b1, 32'hFFF9, 32'h2, 32'hFFFF_FFFD, 32'hFFFF_FFFF, 32'h08);
      run(SWA_OP_DIV16, 1'b1, 32'h1, 32'h5, 32'h0001_0000, 32'hFFFF_FFFF, 32'h0A);
      run(SWA_OP_DIV32, 1'b1, 32'hFFFF_FF9C, 32'h7, 32'hFFFF_FFF2, 32'hFFFF_FFFE, 32'h08);
      run(SWA_OP_DIV32, 1'b1, 32'h3, 32'h5, 32'h0, 32'h3, 32'h0A);
      run(SWA_OP_DIV32, 1'b1, 32'h5, 32'h0, 32'h0, 32'h3, 32'h1A);
      run(SWA_OP_DIV16, 1'b1, 32'h5, 32'h0001_0000, 32'h0, 32'h3, 32'h1A);
      run(SWA_OP_SUB32, 1'b1, 32'h9, 32'h1, 32'h8, 32'h3, 32'h00);
      // each access fault cause alone blocks the result and raises the error flag
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, `SWA_FAULT_ADDR, 32'h1 << i);
         rdchk(`SWA_FAULT_ADDR, 32'h1 << i, "fault readback");
         run(SWA_OP_SUB32, 1'b1, 32'h14, 32'h1, 32'h8, 32'h3, 32'h10);
      end
      run(SWA_OP_SUB32, 1'b0, 32'h14, 32'h1, 32'h8, 32'h3, 32'h10);
      apb(1'b1, `SWA_FAULT_ADDR, 32'h0);
      run(SWA_OP_SUB32, 1'b1, 32'h14, 32'h1, 32'h13, 32'h3, 32'h00);
      conclude();
   end
endmodule : swa_unit_tb
